//--- rtl/pcto_fifo.sv
`timescale 1ns/1ps
// =====================================================================
// Small synchronous FIFO, valid/ready on both sides
module pcto_fifo #(
	parameter int unsigned WIDTH = 13,             // Word width
	parameter int unsigned DEPTH = 8               // Number of words
) (
	input  wire logic             clk,             // Core clock
	input  wire logic             resetn,          // Asynchronous reset, active low
	input  wire logic             in_valid,        // Write side has a word
	output logic                  in_ready,        // FIFO has room
	input  wire logic [WIDTH-1:0] in_data,         // Word to store
	output logic                  out_valid,       // FIFO holds a word
	input  wire logic             out_ready,       // Drain side takes the word
	output logic      [WIDTH-1:0] out_data         // Oldest word
);

	localparam int unsigned AW = $clog2(DEPTH);   // Pointer width

	logic [WIDTH-1:0] mem_q [DEPTH];               // Storage
	logic [AW-1:0]    wr_q;                        // Write pointer
	logic [AW-1:0]    rd_q;                        // Read pointer
	logic [AW:0]      cnt_q;                       // Words held
	logic             push;                        // Word accepted
	logic             pop;                         // Word removed

	// =================================================================
	// Handshake
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	// Storage needs no reset; count guards every read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			// Simultaneous push and pop leave the count unchanged
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // pcto_fifo

//--- rtl/pcto_pkg.sv
// =====================================================================
// Shared constants for the trace output port
package pcto_pkg;

	// =================================================================
	// Widths
	localparam int unsigned PC_W     = 4;            // Trace PC bits, bit 0 shares the test-data-out pin
	localparam int unsigned STATUS_W = 9;            // Trace status bus width
	localparam int unsigned WORD_W   = PC_W + STATUS_W; // One trace word
	localparam int unsigned STATUS_LSB = 0;          // Status field position in a word
	localparam int unsigned PC_LSB     = STATUS_W;   // PC field position in a word

	// =================================================================
	// Buffering
	localparam int unsigned FIFO_DEPTH = 8;          // Trace words held ahead of the pins

	// =================================================================
	// Debug clock divider
	localparam int unsigned CORE_CLK_HZ = 40000000;  // Core clock rate
	localparam int unsigned DIV_RATIO   = 3;         // Core clock cycles per debug clock period
	localparam logic [1:0]  DIV_LAST    = 2'(DIV_RATIO - 1); // Terminal divider count
	localparam logic [1:0]  DIV_RESET   = 2'h0;      // Divider count after power-on reset

	// =================================================================
	// Reset values
	localparam logic        STRAP_RESET  = 1'b1;     // Pins default role until the strap is caught
	localparam logic [PC_W-1:0]     PC_IDLE     = 4'hF; // Debug role, not tracing: all high
	localparam logic [STATUS_W-1:0] STATUS_IDLE = 9'h000; // Debug role, not tracing: low

	// =================================================================
	// Pin role state, one-hot
	typedef enum logic [2:0] {
		PCTO_ROLE_RESET   = 3'h1,                  // Inside reset, strap being caught
		PCTO_ROLE_DEFAULT = 3'h2,                  // Strap high: general inputs and slow clock
		PCTO_ROLE_DEBUG   = 3'h4                   // Strap low: debug trace pins
	} pcto_role_t;

endpackage

//--- rtl/pcto_port.sv
`timescale 1ns/1ps
module pcto_port (
	input  wire logic                          clk,                      // Core clock, 40 MHz
	input  wire logic                          resetn,                   // System reset, active low
	input  wire logic                          power_on_reset_n,         // Power-on reset pin, active low
	input  wire logic                          test_reset_n,             // JTAG test reset pin, active low
	input  wire logic                          tdo_pin_i,                // Level on test-data-out pin
	input  wire logic                          slow_clock_in,            // 32.768 kHz clock from oscillator
	input  wire logic                          trace_mode_sel,           // PC trace mode selected by debug unit
	input  wire logic                          trace_valid,              // Trace word offered
	output logic                               trace_ready,              // Trace word accepted
	input  wire logic [pcto_pkg::WORD_W-1:0]   trace_word,               // {pc bits, status bits}
	output logic                               debug_trace_clock,        // Debug trace clock pin
	output logic                               debug_trace_clock_oe,     // Drive enable of that pin
	output logic [pcto_pkg::PC_W-1:0]          trace_pc_bits,            // Trace PC pins
	output logic [pcto_pkg::PC_W-1:0]          trace_pc_bits_oe,         // Drive enables, per pin
	output logic [pcto_pkg::STATUS_W-1:0]      trace_status_bus,         // Trace status pins
	output logic [pcto_pkg::STATUS_W-1:0]      trace_status_bus_oe,      // Drive enables, per pin
	output logic                               slow_clock_buffer_out,    // Buffered slow clock pin
	output logic                               slow_clock_buffer_out_oe, // Drive enable of that pin
	output logic                               bus_timeout_detect_en,    // Internal bus timeout detection on
	output logic                               clock_generator_init      // Clock generator held in init
);

	// =================================================================
	// Declarations
	logic                            trst_s1_q, trst_s2_q;   // Test reset synchroniser
	logic                            tdo_s1_q, tdo_s2_q;     // Strap synchroniser
	logic                            slow_s1_q, slow_s2_q;   // Slow clock synchroniser
	logic                            in_reset_q;             // System reset seen, not yet released
	logic                            strap_q;                // Caught test-data-out level
	pcto_pkg::pcto_role_t            role_q;                 // Pin role
	logic [1:0]                      div_q;                  // Divider count
	logic                            cg_init_q;              // Clock generator init flag
	logic                            tick;                   // Start of a debug clock period
	logic                            debug_trace_clock_q;                 // Debug trace clock level
	logic                            tracing;                // Debug role and trace mode on
	logic                            fifo_valid;             // Word waiting for the pins
	logic [pcto_pkg::WORD_W-1:0]     fifo_word;              // Oldest buffered word
	logic                            pop;                    // Word moved to the pins
	logic [pcto_pkg::PC_W-1:0]       pc_q;                   // Registered PC pins
	logic [pcto_pkg::STATUS_W-1:0]   status_q;               // Registered status pins
	logic                            slow_out_q;             // Registered slow clock pin

	// =================================================================
	// Test reset and slow clock synchronisers, run from power-on so they work in system reset
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n) begin
			trst_s1_q <= 1'b0;
			trst_s2_q <= 1'b0;
			slow_s1_q <= 1'b0;
			slow_s2_q <= 1'b0;
		end else begin
			trst_s1_q <= test_reset_n;
			trst_s2_q <= trst_s1_q;
			slow_s1_q <= slow_clock_in;
			slow_s2_q <= slow_s1_q;
		end
	end

	// Strap synchroniser has no reset: with both resets held low together it must
	// still follow the pin, or the capture flop would only ever see the reset level
	always_ff @(posedge clk) begin
		tdo_s1_q <= tdo_pin_i;
		tdo_s2_q <= tdo_s1_q;
	end

	// =================================================================
	// Bus timeout detection off while the test reset is not asserted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_timeout_detect_en <= 1'b1;
		end else begin
			bus_timeout_detect_en <= !trst_s2_q;
		end
	end

	// =================================================================
	// Clock generator: only the power-on reset initialises it
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n) begin
			cg_init_q <= 1'b1;
			div_q     <= pcto_pkg::DIV_RESET;
			debug_trace_clock_q    <= 1'b0;
		end else begin
			cg_init_q <= 1'b0;
			// Count 0..2; system reset does not disturb the divider
			div_q  <= (div_q == pcto_pkg::DIV_LAST) ? pcto_pkg::DIV_RESET : div_q + 2'h1;
			// High for one core cycle of three, rising at the period start;
			// gated here so a mode change never cuts a short first period
			debug_trace_clock_q <= (div_q == pcto_pkg::DIV_LAST) && tracing;
		end
	end
	assign clock_generator_init = cg_init_q;
	assign tick                 = (div_q == pcto_pkg::DIV_LAST);

	// =================================================================
	// Strap capture: follows the pin while in reset, frozen after
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_reset_q <= 1'b1;
		end else begin
			in_reset_q <= 1'b0;
		end
	end

	// Held in power-on domain so it can track the pin during system reset
	always_ff @(posedge clk or negedge power_on_reset_n) begin
		if (!power_on_reset_n) begin
			strap_q <= pcto_pkg::STRAP_RESET;
		end else if (in_reset_q) begin
			strap_q <= tdo_s2_q;
		end
	end

	// Role follows the caught strap once reset has ended
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			role_q <= pcto_pkg::PCTO_ROLE_RESET;
		end else begin
			case (role_q)
				pcto_pkg::PCTO_ROLE_RESET: begin
					// Last capture happened on the edge that cleared in_reset_q; strap_q is already final
					if (!in_reset_q) begin
						role_q <= strap_q ? pcto_pkg::PCTO_ROLE_DEFAULT : pcto_pkg::PCTO_ROLE_DEBUG;
					end
				end
				pcto_pkg::PCTO_ROLE_DEFAULT: role_q <= pcto_pkg::PCTO_ROLE_DEFAULT; // Held until reset
				pcto_pkg::PCTO_ROLE_DEBUG:   role_q <= pcto_pkg::PCTO_ROLE_DEBUG;   // Held until reset
				default:                     role_q <= pcto_pkg::PCTO_ROLE_RESET;
			endcase
		end
	end

	// =================================================================
	// Trace buffering: the source stalls when the pins fall behind
	assign tracing = (role_q == pcto_pkg::PCTO_ROLE_DEBUG) && trace_mode_sel;
	assign pop     = tracing && tick && fifo_valid;

	pcto_fifo #(
		.WIDTH (pcto_pkg::WORD_W),
		.DEPTH (pcto_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (trace_valid),
		.in_ready  (trace_ready),
		.in_data   (trace_word),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_word)
	);

	// =================================================================
	// While tracing, trace pins change only with the rising debug clock edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_q     <= pcto_pkg::PC_IDLE;
			status_q <= pcto_pkg::STATUS_IDLE;
		end else if (!tracing) begin
			// Debug role idle level: PC all high, status low
			pc_q     <= pcto_pkg::PC_IDLE;
			status_q <= pcto_pkg::STATUS_IDLE;
		end else if (pop) begin
			pc_q     <= fifo_word[pcto_pkg::PC_LSB +: pcto_pkg::PC_W];
			status_q <= fifo_word[pcto_pkg::STATUS_LSB +: pcto_pkg::STATUS_W];
		end
		// An empty buffer repeats the last word; the probe sees no gap marker
	end

	// =================================================================
	// Slow clock buffer: passes the clock only in the default role
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slow_out_q <= 1'b0;
		end else begin
			slow_out_q <= (role_q == pcto_pkg::PCTO_ROLE_DEFAULT) && slow_s2_q;
		end
	end

	// =================================================================
	// Pin drive by role
	always_comb begin
		debug_trace_clock        = 1'b0;
		debug_trace_clock_oe     = 1'b0;
		trace_pc_bits            = pc_q;
		trace_pc_bits_oe         = '0;
		trace_status_bus         = status_q;
		trace_status_bus_oe      = '0;
		slow_clock_buffer_out    = slow_out_q;
		slow_clock_buffer_out_oe = 1'b0;
		case (role_q)
			pcto_pkg::PCTO_ROLE_DEFAULT: begin
				// Status bits 8..1 released as inputs, bit 0 carries slow clock
				trace_status_bus[0]      = slow_out_q;
				trace_status_bus_oe[0]   = 1'b1;
				slow_clock_buffer_out_oe = 1'b1;
			end
			pcto_pkg::PCTO_ROLE_DEBUG: begin
				debug_trace_clock        = debug_trace_clock_q;
				debug_trace_clock_oe     = 1'b1;
				// Bit 0 belongs to the JTAG port unless tracing
				trace_pc_bits_oe         = {{(pcto_pkg::PC_W-1){1'b1}}, tracing};
				trace_status_bus_oe      = '1;
				slow_clock_buffer_out    = 1'b0;
				slow_clock_buffer_out_oe = 1'b1;
			end
			default: begin
				// In reset: everything released
			end
		endcase
	end

endmodule // pcto_port

//--- testbench/pcto_port_checker.sv
`timescale 1ns/1ps
// ========================================
// Pin protocol checker for the trace port
module pcto_port_checker (
	input wire logic       clk,                      // Core clock
	input wire logic       resetn,                   // System reset
	input wire logic       power_on_reset_n,         // Power-on reset
	input wire logic       test_reset_n,             // Test reset pin
	input wire logic       slow_clock_in,            // Slow clock in
	input wire logic       trace_mode_sel,           // Trace mode
	input wire logic       debug_trace_clock,        // Trace clock pin
	input wire logic       debug_trace_clock_oe,     // Its enable
	input wire logic [3:0] trace_pc_bits,            // PC pins
	input wire logic [3:0] trace_pc_bits_oe,         // Their enables
	input wire logic [8:0] trace_status_bus,         // Status pins
	input wire logic [8:0] trace_status_bus_oe,      // Their enables
	input wire logic       slow_clock_buffer_out,    // Slow clock pin
	input wire logic       slow_clock_buffer_out_oe, // Its enable
	input wire logic       bus_timeout_detect_en,    // Timeout detection
	input wire logic       clock_generator_init      // Clock generator init
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn || !power_on_reset_n);
	// ========================================
	// Timeout detection follows test reset after three edges
	AST_TMO_OFF: assert property (test_reset_n [*3] |=> !bus_timeout_detect_en)
		else $error("timeout detection left on");
	AST_TMO_ON: assert property (!test_reset_n [*3] |=> bus_timeout_detect_en)
		else $error("timeout detection left off");
	// Trace clock: one high cycle in three
	AST_DIV_LOW: assert property ($rose(debug_trace_clock) |=> !debug_trace_clock [*2])
		else $error("trace clock high too long");
	AST_DIV_PERIOD: assert property ($rose(debug_trace_clock) ##1 trace_mode_sel [*2] |=> debug_trace_clock)
		else $error("trace clock period not three");
	// Pins only move with the trace clock while tracing steadily
	AST_PIN_STEP: assert property (debug_trace_clock_oe && trace_mode_sel && $past(trace_mode_sel)
		&& $past(trace_mode_sel, 2) && !$stable({trace_pc_bits, trace_status_bus}) |-> $rose(debug_trace_clock))
		else $error("trace pins moved off the clock");
	AST_IDLE: assert property ((debug_trace_clock_oe && !trace_mode_sel) [*4] |->
		!debug_trace_clock && trace_pc_bits == 4'hF && trace_status_bus == 9'h000)
		else $error("idle trace pins wrong");
	AST_DEBUG_ROLE: assert property (debug_trace_clock_oe |->
		trace_status_bus_oe == 9'h1FF && trace_pc_bits_oe == {3'h7, trace_mode_sel} && !slow_clock_buffer_out)
		else $error("debug role pins wrong");
	AST_DEFAULT_ROLE: assert property (slow_clock_buffer_out_oe && !debug_trace_clock_oe |->
		trace_status_bus_oe == 9'h001 && trace_pc_bits_oe == 4'h0 && trace_status_bus[0] == slow_clock_buffer_out)
		else $error("default role pins wrong");
	// Slow clock: two sync flops and one output flop
	AST_SLOW: assert property (slow_clock_buffer_out_oe && !debug_trace_clock_oe
		&& $past(slow_clock_buffer_out_oe, 3) |-> slow_clock_buffer_out == $past(slow_clock_in, 3))
		else $error("slow clock not passed through");
	AST_ROLE_HOLD: assert property ($past(debug_trace_clock_oe || slow_clock_buffer_out_oe)
		|-> $stable(debug_trace_clock_oe))
		else $error("pin role changed outside reset");
	AST_CG_INIT: assert property (disable iff (!resetn)
		$rose(power_on_reset_n) |-> clock_generator_init ##1 !clock_generator_init)
		else $error("clock generator init wrong");
endmodule // pcto_port_checker

bind pcto_port pcto_port_checker i_chk (.clk, .resetn, .power_on_reset_n, .test_reset_n, .slow_clock_in,
	.trace_mode_sel, .debug_trace_clock, .debug_trace_clock_oe, .trace_pc_bits, .trace_pc_bits_oe,
	.trace_status_bus, .trace_status_bus_oe, .slow_clock_buffer_out, .slow_clock_buffer_out_oe,
	.bus_timeout_detect_en, .clock_generator_init);

//--- testbench/pcto_port_tb.sv
`timescale 1ns/1ps
// ========================================
// Self-checking bench for the trace port
module pcto_port_tb;
	logic       clk = 1'b0, resetn = 1'b0, power_on_reset_n = 1'b0; // Clock and resets
	logic       test_reset_n = 1'b1, tdo_pin_i = 1'b0, slow_clock_in = 1'b0; // Pin levels
	logic       trace_mode_sel = 1'b0, trace_valid = 1'b0; // Trace control
	logic [12:0] trace_word = 13'h0000; // Offered word
	logic       trace_ready, debug_trace_clock, debug_trace_clock_oe, slow_clock_buffer_out; // Outputs
	logic       slow_clock_buffer_out_oe, bus_timeout_detect_en, clock_generator_init; // Outputs
	logic [3:0] trace_pc_bits, trace_pc_bits_oe; // PC pins
	logic [8:0] trace_status_bus, trace_status_bus_oe; // Status pins
	logic [12:0] exp_q[$]; // Words the probe should see
	int         n_tests = 0, n_mismatch = 0, cycles = 0; // Counters
	pcto_port i_dut (.clk, .resetn, .power_on_reset_n, .test_reset_n, .tdo_pin_i, .slow_clock_in, .trace_mode_sel,
		.trace_valid, .trace_ready, .trace_word, .debug_trace_clock, .debug_trace_clock_oe, .trace_pc_bits,
		.trace_pc_bits_oe, .trace_status_bus, .trace_status_bus_oe, .slow_clock_buffer_out,
		.slow_clock_buffer_out_oe, .bus_timeout_detect_en, .clock_generator_init);
	pcto_probe i_probe (.debug_trace_clock, .debug_trace_clock_oe, .trace_pc_bits, .trace_status_bus);
	always #12.5 clk = ~clk;
	// ========================================
	// Helpers
	function automatic logic [8:0] exp_status_oe(input logic strap);
		return strap ? 9'h001 : 9'h1FF; // Default role drives only the slow clock bit
	endfunction
	function automatic logic [12:0] rand_word();
		logic [31:0] r;
		r = $urandom;
		return r[12:0];
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Strap is set up while reset is low so it is caught inside reset
	task automatic do_reset(input logic pon, input logic strap);
		resetn <= 1'b0;
		power_on_reset_n <= !pon;
		tdo_pin_i <= strap;
		repeat (12) @(posedge clk);
		check("clock generator init", clock_generator_init, pon);
		resetn <= 1'b1;
		power_on_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// Holds the word until the edge that takes it
	task automatic push(input logic [12:0] w);
		trace_valid <= 1'b1;
		trace_word <= w;
		exp_q.push_back(w);
		@(posedge clk);
		while (!trace_ready) @(posedge clk);
	endtask
	// ========================================
	// Watchdog against a hung handshake
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// ========================================
	// Main sequence
	initial begin
		void'($urandom(50128));
		do_reset(1'b1, 1'b0);
		check("status enables", trace_status_bus_oe, exp_status_oe(1'b0));
		check("slow out in debug role", slow_clock_buffer_out, 1'b0);
		for (int v = 0; v < 2; v++) begin
			test_reset_n <= v[0];
			repeat (4) @(posedge clk);
			check("timeout enable", bus_timeout_detect_en, !v[0]);
		end
		tdo_pin_i <= 1'b1;
		repeat (5) @(posedge clk);
		check("debug role kept", debug_trace_clock_oe, 1'b1);
		// Fill with tracing stalled, all-ones and all-zeros first
		for (int i = 0; i < 8; i++) push(i == 0 ? 13'h1FFF : i == 1 ? 13'h0000 : rand_word());
		trace_valid <= 1'b0;
		@(posedge clk);
		check("ready when full", trace_ready, 1'b0);
		trace_mode_sel <= 1'b1;
		for (int i = 0; i < 4; i++) push(rand_word());
		trace_valid <= 1'b0;
		check("pc enables tracing", trace_pc_bits_oe, 4'hF);
		for (int t = 0; t < 200 && i_probe.seen.size() < 12; t++) @(posedge clk);
		for (int i = 0; i < 12; i++) check("probe word", i_probe.seen[i], exp_q[i]);
		trace_mode_sel <= 1'b0;
		repeat (6) @(posedge clk);
		check("idle pc pins", trace_pc_bits, 4'hF);
		check("idle pc enables", trace_pc_bits_oe, 4'hE);
		// System reset only, strap high: default role
		do_reset(1'b0, 1'b1);
		check("status enables", trace_status_bus_oe, exp_status_oe(1'b1));
		check("pc enables", trace_pc_bits_oe, 4'h0);
		for (int i = 0; i < 30; i++) begin
			slow_clock_in <= i[0];
			repeat (4) @(posedge clk);
			check("slow clock out", slow_clock_buffer_out, slow_clock_in);
			check("status bit zero", trace_status_bus[0], slow_clock_in);
		end
		trace_mode_sel <= 1'b1;
		repeat (6) @(posedge clk);
		check("trace clock in default role", debug_trace_clock, 1'b0);
		trace_mode_sel <= 1'b0;
		do_reset(1'b1, 1'b1);
		tdo_pin_i <= 1'b0;
		repeat (5) @(posedge clk);
		check("default role kept", debug_trace_clock_oe, 1'b0);
		give_verdict();
	end
endmodule // pcto_port_tb

//--- testbench/pcto_probe.sv
`timescale 1ns/1ps
// ========================================
// Debug probe: catches one word per trace clock period
module pcto_probe (
	input wire logic                          debug_trace_clock,    // Trace clock pin
	input wire logic                          debug_trace_clock_oe, // Pin driven
	input wire logic [pcto_pkg::PC_W-1:0]     trace_pc_bits,        // PC pins
	input wire logic [pcto_pkg::STATUS_W-1:0] trace_status_bus      // Status pins
);
	logic [pcto_pkg::WORD_W-1:0] seen[$]; // Words caught, oldest first
	// Falling edge: pins launch on the rise, so one core cycle later is clear of the race
	always @(negedge debug_trace_clock) begin
		if (debug_trace_clock_oe) begin
			seen.push_back({trace_pc_bits, trace_status_bus});
		end
	end
endmodule // pcto_probe
